// [bench/testbench.sv]
// testbench: apb registers, edge channels, current gating and interrupt flag of the edge control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cte_pkg::*;
	localparam logic [ADDR_W-1:0] ADR [5] = '{CUR_CTRL_ADDR, EDGE_CFG_ADDR, UNIT_CTRL_ADDR, IRQ_FLAG_ADDR, IRQ_EN_ADDR};
	localparam int                MSK [5] = '{8'hff, 8'hff, 8'h9e, 8'h04, 8'h04};
	logic              clk     = 1'b0;
	logic              rst_b   = 1'b0;
	logic              ce      = 1'b1;
	logic              psel    = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite  = 1'b0;
	logic [ADDR_W-1:0] paddr   = '0;
	logic [31:0]       pwdata  = '0;
	logic [3:0]        src     = 4'hf;
	logic [31:0]       rd;
	logic [31:0]       seed    = 32'hacdcaab1;
	logic              err;
	logic              pready, pslverr, cur_en, dis, dly, cmp2, irq;
	logic [31:0]       prdata;
	logic [1:0]        rng;
	logic [5:0]        trim;
	int                mreg [5] = '{0, 0, 0, 0, 0}; // model of the register file
	int                error_cnt = 0;
	int                cmp_count = 0;
	logic [5:0]        trims [4] = '{6'h00, 6'h20, 6'h1f, 6'h15};

	cte_top DUT (.clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.edge_pin_a(src[0]), .edge_pin_b(src[1]), .event_trig_1(src[2]), .event_trig_2(src[3]),
		.current_enable(cur_en), .current_range_sel(rng), .current_trim(trim), .discharge_ctrl(dis),
		.delay_mode_sel(dly), .comparator2_neg_input(cmp2), .irq(irq));

	// clock generator
	always #12.5 clk = ~clk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer; holds the request until pready is seen high, for at most 50 cycles
	task automatic apb(input logic wr_en, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr_en;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input int i, input logic [7:0] d);
		apb(1'b1, ADR[i], {24'h0, d});
		mreg[i] = d & MSK[i];
	endtask

	task automatic rdchk(input int i);
		apb(1'b0, ADR[i], 32'h0);
		chk(rd, 32'(mreg[i]));
		chk(32'(err), 32'h0);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// watchdog against a hung handshake
	initial begin
		#(25.0 * 20000);
		error_cnt++;
		wrap_up();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		cyc(3);
		// reset values and an unmapped address
		for (int i = 0; i < 5; i++) rdchk(i);
		apb(1'b0, 12'h014, 32'h0);
		chk(rd, 32'h0);
		chk(32'(err), 32'h1);
		chk({cur_en, dis, dly, cmp2, irq}, 32'h0);
		$display("test reset done");
		// every range code with the boundary trim codes and one random code
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			if (k == 3) trims[k] = seed[5:0];
			wr(0, {trims[k], 2'(k)});
			rdchk(0);
			chk(32'(rng), 32'(k));
			chk(32'(trim), 32'(trims[k]));
		end
		$display("test current setting done");
		// each source code on both channels, level low response, current window and interrupt
		wr(2, 8'h00);
		wr(2, 8'h80);
		wr(1, 8'h00);
		wr(2, 8'h88);
		wr(4, 8'h04);
		for (int s = 0; s < 4; s++) begin
			wr(1, {1'b0, 2'(s + 1), 1'b0, 2'(s), 2'b00});
			@(posedge clk) src[s] <= 1'b0;
			cyc(10);
			mreg[1] = mreg[1] | 1;
			rdchk(1);
			chk(32'(cur_en), 32'h1);
			@(posedge clk) src[2'(s + 1)] <= 1'b0;
			cyc(10);
			mreg[1] = mreg[1] | 2;
			mreg[3] = 4;
			rdchk(1);
			rdchk(3);
			chk({cur_en, irq}, 32'h1);
			@(posedge clk) src <= 4'hf;
			cyc(6);
			wr(4, 8'h00);
			cyc(2);
			chk(32'(irq), 32'h0);
			wr(3, 8'h00);
			wr(4, 8'h04);
			wr(1, 8'h00);
		end
		$display("test edge sources done");
		// changing polarity to match the present level sets the flag at once
		wr(2, 8'h80);
		@(posedge clk) src <= 4'h0;
		cyc(6);
		wr(1, 8'h90);
		wr(2, 8'h88);
		cyc(8);
		rdchk(1);
		wr(1, 8'h80);
		cyc(6);
		mreg[1] = 8'h81;
		rdchk(1);
		chk(32'(cur_en), 32'h1);
		@(posedge clk) src <= 4'hf;
		cyc(6);
		wr(1, 8'h00);
		cyc(2);
		mreg[3] = 4;
		rdchk(3);
		wr(3, 8'h00);
		$display("test polarity done");
		// ordering holds edge 2 back until edge 1
		wr(2, 8'h8c);
		wr(1, 8'h20);
		@(posedge clk) src[1] <= 1'b0;
		cyc(10);
		rdchk(1);
		chk(32'(cur_en), 32'h0);
		@(posedge clk) src[0] <= 1'b0;
		cyc(10);
		mreg[1] = 8'h23;
		rdchk(1);
		@(posedge clk) src <= 4'hf;
		cyc(6);
		wr(1, 8'h00);
		wr(3, 8'h00);
		$display("test ordering done");
		// unit or edge inputs disabled: no flag, no current
		for (int k = 0; k < 2; k++) begin
			wr(2, k ? 8'h80 : 8'h08);
			wr(1, 8'h20);
			@(posedge clk) src <= 4'h0;
			cyc(10);
			rdchk(1);
			chk(32'(cur_en), 32'h0);
			@(posedge clk) src <= 4'hf;
			cyc(6);
		end
		$display("test disabled done");
		// software flags, delay mode routing and discharge
		wr(2, 8'h92);
		wr(1, 8'h01);
		cyc(3);
		chk({cur_en, cmp2, dis, dly}, 32'hf);
		wr(1, 8'h03);
		cyc(3);
		chk({cur_en, cmp2}, 32'h0);
		mreg[3] = 4;
		rdchk(3);
		wr(2, 8'h02);
		cyc(3);
		chk({cur_en, dis, dly}, 32'h0);
		rdchk(2);
		$display("test software flags done");
		wrap_up();
	end
endmodule // testbench
`default_nettype wire

// [core/cte_pkg.sv]
// package: register map, field layouts and reset values of the edge control block
package cte_pkg;

	localparam int unsigned ADDR_W = 12;

	// register byte addresses
	localparam logic [ADDR_W-1:0] CUR_CTRL_ADDR  = 12'h000;
	localparam logic [ADDR_W-1:0] EDGE_CFG_ADDR  = 12'h004;
	localparam logic [ADDR_W-1:0] UNIT_CTRL_ADDR = 12'h008;
	localparam logic [ADDR_W-1:0] IRQ_FLAG_ADDR  = 12'h00c;
	localparam logic [ADDR_W-1:0] IRQ_EN_ADDR    = 12'h010;

	// interrupt bit position in flag and enable registers
	localparam int unsigned IRQ_BIT = 2;

	// edge source codes
	localparam logic [1:0] SRC_PIN_A = 2'h0;
	localparam logic [1:0] SRC_PIN_B = 2'h1;
	localparam logic [1:0] SRC_TRG_1 = 2'h2;
	localparam logic [1:0] SRC_TRG_2 = 2'h3;
	localparam int unsigned SRC_N    = 4;

	// current_source_control layout
	typedef struct packed {
		logic [5:0] current_trim;      // 7:2, two's complement steps
		logic [1:0] current_range_sel; // 1:0, 00 lowest range
	} cte_cur_ctrl_type;

	// edge_configuration layout
	typedef struct packed {
		logic       edge2_polarity;    // 7
		logic [1:0] edge2_source_sel;  // 6:5
		logic       edge1_polarity;    // 4
		logic [1:0] edge1_source_sel;  // 3:2
		logic       edge2_flag;        // 1
		logic       edge1_flag;        // 0
	} cte_edge_cfg_type;

	// unit_control layout
	typedef struct packed {
		logic       unit_enable;        // 7
		logic [1:0] spare;              // 6:5
		logic       delay_mode_sel;     // 4
		logic       edge_inputs_enable; // 3
		logic       edge_order_enable;  // 2
		logic       discharge_ctrl;     // 1
		logic       spare0;             // 0
	} cte_unit_ctrl_type;

	localparam cte_cur_ctrl_type  CUR_CTRL_RST  = '{current_trim: 6'h00, current_range_sel: 2'h0};
	localparam cte_edge_cfg_type  EDGE_CFG_RST  = '{default: 1'b0};
	localparam cte_unit_ctrl_type UNIT_CTRL_RST = '{default: 1'b0};

endpackage

// [core/cte_top.sv]
// module: edge channels, status flags, current-source gating and apb register file
//
// Contract
// - two-bit range field, 00 lowest range
// - six-bit trim field, bits 7:2, about 2% steps
// - each channel selects one of four sources
// - channels react to level, not transitions
// - per-channel polarity bits 7 and 4
// - polarity resets to negative-going response
// - ordering makes edge 2 wait for edge 1
// - detected response sets matching status flag
// - config matching current level sets flag immediately
// - current on only when exactly one flag
// - software may write flags to steer current
// - interrupt flag set after enable then disable
// - interrupt request needs flag and enable bit
// - unit enable bit turns unit on/off
// - discharge while bit set; software times it (code also requires unit enable bit 7 set)
// - edge enable bit gates edge recognition
// - mode bit picks measurement or delay
// - delay mode routes current to comparator 2
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module cte_top
	import cte_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              ce,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// edge sources, asynchronous
	input  wire logic              edge_pin_a,
	input  wire logic              edge_pin_b,
	input  wire logic              event_trig_1,
	input  wire logic              event_trig_2,
	// analog control
	output logic                   current_enable,
	output logic [1:0]             current_range_sel,
	output logic [5:0]             current_trim,
	output logic                   discharge_ctrl,
	output logic                   delay_mode_sel,
	output logic                   comparator2_neg_input,
	output logic                   irq
);

	logic              rst_meta_reg;
	logic              rst_n;
	cte_cur_ctrl_type  cur_reg;
	cte_edge_cfg_type  cfg_reg;
	cte_unit_ctrl_type ctl_reg;
	logic              irq_flag_reg;
	logic              irq_en_reg;
	logic              cur_on_reg;
	logic [SRC_N-1:0]  src_raw;
	logic [SRC_N-1:0]  sync1_reg;
	logic [SRC_N-1:0]  sync2_reg;
	logic [SRC_N-1:0]  sync3_reg;
	logic [SRC_N-1:0]  src_reg;
	logic              wr_en;
	logic              rd_setup;
	logic              hit;
	logic              wr_cur;
	logic              wr_cfg;
	logic              wr_ctl;
	logic              wr_iflag;
	logic              wr_ien;
	logic              act1;
	logic              act2;
	logic              set1;
	logic              set2;
	logic              cur_on_next;
	logic [31:0]       rd_data;
	cte_edge_cfg_type  cfg_wr;

	// reset release through two flip-flops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// apb decode, zero wait states while clock enable is high
	assign pready   = ce;
	assign wr_en    = psel & penable & pwrite & ce;
	assign rd_setup = psel & ~penable & ~pwrite & ce;
	assign hit      = (paddr == CUR_CTRL_ADDR) | (paddr == EDGE_CFG_ADDR) | (paddr == UNIT_CTRL_ADDR)
	                | (paddr == IRQ_FLAG_ADDR) | (paddr == IRQ_EN_ADDR);
	assign pslverr  = psel & penable & ~hit;
	assign wr_cur   = wr_en & (paddr == CUR_CTRL_ADDR);
	assign wr_cfg   = wr_en & (paddr == EDGE_CFG_ADDR);
	assign wr_ctl   = wr_en & (paddr == UNIT_CTRL_ADDR);
	assign wr_iflag = wr_en & (paddr == IRQ_FLAG_ADDR);
	assign wr_ien   = wr_en & (paddr == IRQ_EN_ADDR);

	// read mux; unmapped addresses and upper bits read zero
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (paddr)
			CUR_CTRL_ADDR:  rd_data[7:0]       = cur_reg;
			EDGE_CFG_ADDR:  rd_data[7:0]       = cfg_reg;
			UNIT_CTRL_ADDR: rd_data[7:0]       = ctl_reg;
			IRQ_FLAG_ADDR:  rd_data[IRQ_BIT]   = irq_flag_reg;
			IRQ_EN_ADDR:    rd_data[IRQ_BIT]   = irq_en_reg;
			default:        rd_data            = 32'h0000_0000;
		endcase
	end

	// read data captured in the setup phase, stable through the access phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= rd_data;
		end
	end

	// current source control register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_reg <= CUR_CTRL_RST;
		end else if (wr_cur) begin
			cur_reg <= cte_cur_ctrl_type'(pwdata[7:0]);
		end
	end

	// unit control register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_reg <= UNIT_CTRL_RST;
		end else if (wr_ctl) begin
			ctl_reg       <= cte_unit_ctrl_type'(pwdata[7:0]);
			ctl_reg.spare <= 2'h0;
			ctl_reg.spare0 <= 1'b0;
		end
	end

	// three-stage capture of asynchronous sources; first stage feeds only the second
	assign src_raw = {event_trig_2, event_trig_1, edge_pin_b, edge_pin_a};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
		end else if (ce) begin
			sync1_reg <= src_raw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// accepted level changes only when the second and third stages agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			src_reg <= '0;
		end else if (ce) begin
			for (int i = 0; i < SRC_N; i++) begin
				if (sync2_reg[i] == sync3_reg[i]) begin
					src_reg[i] <= sync3_reg[i];
				end
			end
		end
	end

	// polarity-adjusted level of each selected source; polarity 0 responds to low
	assign act1 = ~(src_reg[cfg_reg.edge1_source_sel] ^ cfg_reg.edge1_polarity);
	assign act2 = ~(src_reg[cfg_reg.edge2_source_sel] ^ cfg_reg.edge2_polarity);

	// hardware set terms, gated by unit enable and edge enable; edge 2 also by ordering
	assign set1 = ctl_reg.unit_enable & ctl_reg.edge_inputs_enable & act1;
	assign set2 = ctl_reg.unit_enable & ctl_reg.edge_inputs_enable & act2
	            & (~ctl_reg.edge_order_enable | cfg_reg.edge1_flag);

	// write data seen through the edge configuration layout
	assign cfg_wr = cte_edge_cfg_type'(pwdata[7:0]);

	// edge configuration register; hardware set wins over a software write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= EDGE_CFG_RST;
		end else if (ce) begin
			if (wr_cfg) begin
				cfg_reg            <= cfg_wr;
				cfg_reg.edge1_flag <= cfg_wr.edge1_flag | set1;
				cfg_reg.edge2_flag <= cfg_wr.edge2_flag | set2;
			end else begin
				cfg_reg.edge1_flag <= cfg_reg.edge1_flag | set1;
				cfg_reg.edge2_flag <= cfg_reg.edge2_flag | set2;
			end
		end
	end

	// current on only while exactly one flag is set and the unit is enabled
	assign cur_on_next = ctl_reg.unit_enable & (cfg_reg.edge1_flag ^ cfg_reg.edge2_flag);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_on_reg <= 1'b0;
		end else if (ce) begin
			cur_on_reg <= cur_on_next;
		end
	end

	// interrupt flag set on current turning off while the unit is enabled; set wins over a software clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_flag_reg <= 1'b0;
		end else if (ce) begin
			if (cur_on_reg & ~cur_on_next & ctl_reg.unit_enable) begin
				irq_flag_reg <= 1'b1;
			end else if (wr_iflag) begin
				irq_flag_reg <= pwdata[IRQ_BIT];
			end
		end
	end

	// interrupt enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_en_reg <= 1'b0;
		end else if (wr_ien) begin
			irq_en_reg <= pwdata[IRQ_BIT];
		end
	end

	// outputs
	assign irq                   = irq_flag_reg & irq_en_reg;
	assign current_enable        = cur_on_reg;
	assign current_range_sel     = cur_reg.current_range_sel;
	assign current_trim          = cur_reg.current_trim;
	assign discharge_ctrl        = ctl_reg.discharge_ctrl & ctl_reg.unit_enable;
	assign delay_mode_sel        = ctl_reg.delay_mode_sel;
	assign comparator2_neg_input = ctl_reg.delay_mode_sel & cur_on_reg;

	// checks
	a_flag1_level: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & set1) |=> cfg_reg.edge1_flag) else $error("edge1 flag not set on active level");
	a_order_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & ctl_reg.edge_order_enable & ~cfg_reg.edge1_flag & ~cfg_reg.edge2_flag & ~wr_cfg)
		|=> ~cfg_reg.edge2_flag) else $error("edge2 accepted before edge1");
	a_pol_reset: assert property (@(posedge clk)
		$rose(rst_n) |-> (~cfg_reg.edge1_polarity & ~cfg_reg.edge2_polarity)) else $error("polarity not negative after reset");
	a_cur_xor: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & cfg_reg.edge1_flag & cfg_reg.edge2_flag) |=> ~current_enable) else $error("current on with both flags");
	a_off_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & ~ctl_reg.unit_enable & ~wr_cfg & ~wr_iflag) |=> (~current_enable & $stable(cfg_reg.edge1_flag)
		& ~$rose(irq_flag_reg))) else $error("disabled unit changed state");
	a_irq_set: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & current_enable & ~cur_on_next & ctl_reg.unit_enable) |=> irq_flag_reg) else $error("no irq flag after cycle");
	a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
		irq |-> (irq_flag_reg & irq_en_reg)) else $error("irq without flag and enable");
	a_edge_gate: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & ~ctl_reg.edge_inputs_enable & ~wr_cfg) |=> $stable(cfg_reg.edge2_flag)) else $error("edge seen while disabled");
	a_sw_flags: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_cfg & pwdata[0] & ~pwdata[1] & ~set2 & ctl_reg.unit_enable) |=> ##1 current_enable)
		else $error("software flag did not start current");
	a_delay_route: assert property (@(posedge clk) disable iff (!rst_n)
		comparator2_neg_input |-> (delay_mode_sel & current_enable)) else $error("comparator route outside delay mode");
	a_range_wr: assert property (@(posedge clk) disable iff (!rst_n)
		wr_cur |=> (current_range_sel == $past(pwdata[1:0]))) else $error("range not written");

	// status flags: hardware set, stickiness and gating
	a_flag2_level: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & set2) |=> cfg_reg.edge2_flag)
		else $error("edge2 flag not set on active level");
	a_flag1_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & cfg_reg.edge1_flag & ~wr_cfg) |=> cfg_reg.edge1_flag)
		else $error("edge1 flag dropped without a write");
	a_flag2_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & cfg_reg.edge2_flag & ~wr_cfg) |=> cfg_reg.edge2_flag)
		else $error("edge2 flag dropped without a write");
	a_edge1_gate: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & ~ctl_reg.edge_inputs_enable & ~wr_cfg) |=> $stable(cfg_reg.edge1_flag))
		else $error("edge1 seen while edge inputs disabled");
	a_unit_flags: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & ~ctl_reg.unit_enable & ~wr_cfg) |=> $stable(cfg_reg.edge2_flag))
		else $error("edge2 flag moved while unit disabled");
	a_order_off: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & ~ctl_reg.edge_order_enable & ctl_reg.unit_enable & ctl_reg.edge_inputs_enable & act2)
		|=> cfg_reg.edge2_flag)
		else $error("edge2 lost without ordering");
	a_order_after: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & ctl_reg.edge_order_enable & cfg_reg.edge1_flag & ctl_reg.unit_enable
		& ctl_reg.edge_inputs_enable & act2) |=> cfg_reg.edge2_flag)
		else $error("edge2 lost after edge1");
	a_sw_both: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_cfg & cfg_wr.edge1_flag & cfg_wr.edge2_flag) |=> ##1 ~current_enable)
		else $error("current on after setting both flags");
	a_sw_clear: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_cfg & ~cfg_wr.edge1_flag & ~cfg_wr.edge2_flag & ~set1 & ~set2)
		|=> (~cfg_reg.edge1_flag & ~cfg_reg.edge2_flag))
		else $error("flags not cleared by write");
	a_pol_wr: assert property (@(posedge clk) disable iff (!rst_n)
		wr_cfg |=> ((cfg_reg.edge1_polarity == $past(cfg_wr.edge1_polarity))
		& (cfg_reg.edge2_polarity == $past(cfg_wr.edge2_polarity))))
		else $error("polarity not written");
	a_sel_wr: assert property (@(posedge clk) disable iff (!rst_n)
		wr_cfg |=> ((cfg_reg.edge1_source_sel == $past(cfg_wr.edge1_source_sel))
		& (cfg_reg.edge2_source_sel == $past(cfg_wr.edge2_source_sel))))
		else $error("source select not written");

	// current source gating
	a_cur_none: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & ~cfg_reg.edge1_flag & ~cfg_reg.edge2_flag) |=> ~current_enable)
		else $error("current on with no flag");
	a_cur_one: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & ctl_reg.unit_enable & (cfg_reg.edge1_flag ^ cfg_reg.edge2_flag)) |=> current_enable)
		else $error("current off with one flag");
	a_cur_unit: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & ~ctl_reg.unit_enable) |=> ~current_enable)
		else $error("current on while unit disabled");
	a_cur_freeze: assert property (@(posedge clk) disable iff (!rst_n)
		~ce |=> $stable(current_enable))
		else $error("current moved while clock enable low");
	a_unit_wr: assert property (@(posedge clk) disable iff (!rst_n)
		wr_ctl |=> (ctl_reg.unit_enable == $past(pwdata[7])))
		else $error("unit enable not written");

	// interrupt flag and request
	a_irq_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & irq_flag_reg & ~wr_iflag) |=> irq_flag_reg)
		else $error("interrupt flag dropped without a write");
	a_irq_clear: assert property (@(posedge clk) disable iff (!rst_n)
		(wr_iflag & ~pwdata[IRQ_BIT] & ~(cur_on_reg & ~cur_on_next & ctl_reg.unit_enable)) |=> ~irq_flag_reg)
		else $error("interrupt flag not cleared");
	a_irq_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & ~irq_flag_reg & ~wr_iflag & ~(cur_on_reg & ~cur_on_next)) |=> ~irq_flag_reg)
		else $error("interrupt flag set without a current cycle");
	a_irq_on: assert property (@(posedge clk) disable iff (!rst_n)
		(irq_flag_reg & irq_en_reg) |-> irq)
		else $error("no request with flag and enable");

	// analog settings, discharge and routing
	a_trim_wr: assert property (@(posedge clk) disable iff (!rst_n)
		wr_cur |=> (current_trim == $past(pwdata[7:2])))
		else $error("trim not written");
	a_range_hold: assert property (@(posedge clk) disable iff (!rst_n)
		~wr_cur |=> $stable(current_range_sel))
		else $error("range moved without a write");
	a_trim_hold: assert property (@(posedge clk) disable iff (!rst_n)
		~wr_cur |=> $stable(current_trim))
		else $error("trim moved without a write");
	a_dis_gate: assert property (@(posedge clk) disable iff (!rst_n)
		discharge_ctrl |-> (ctl_reg.discharge_ctrl & ctl_reg.unit_enable))
		else $error("discharge without bit and unit enable");
	a_dis_on: assert property (@(posedge clk) disable iff (!rst_n)
		(ctl_reg.discharge_ctrl & ctl_reg.unit_enable) |-> discharge_ctrl)
		else $error("discharge bit set but no discharge");
	a_mode_out: assert property (@(posedge clk) disable iff (!rst_n)
		delay_mode_sel |-> ctl_reg.delay_mode_sel)
		else $error("delay mode without its bit");
	a_route_on: assert property (@(posedge clk) disable iff (!rst_n)
		(delay_mode_sel & current_enable) |-> comparator2_neg_input)
		else $error("delay mode current not routed");
	a_meas_route: assert property (@(posedge clk) disable iff (!rst_n)
		~delay_mode_sel |-> ~comparator2_neg_input)
		else $error("comparator driven in measurement mode");

	// source capture filter
	a_sync_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & (sync2_reg[0] != sync3_reg[0])) |=> $stable(src_reg[0]))
		else $error("source taken while stages disagree");
	a_sync_take: assert property (@(posedge clk) disable iff (!rst_n)
		(ce & (sync2_reg[0] == sync3_reg[0])) |=> (src_reg[0] == $past(sync3_reg[0])))
		else $error("agreed source level not taken");

endmodule // cte_top

`default_nettype wire
